// *** rtl/card_ident_cfg.svh ***
/*
 * Constants of the card identification host: card clock timing, command
 * indices, frame lengths and response field positions.
 * Assumes a 20 MHz system clock; included by bare name.
 */
`ifndef CARD_IDENT_CFG_SVH
`define CARD_IDENT_CFG_SVH

`define SYS_CLK_HZ        20000000
`define ID_CLK_MAX_KHZ    400
// half period in system cycles, rounded up so the card clock never exceeds the limit
`define ID_CLK_HALF       ((`SYS_CLK_HZ + 2 * `ID_CLK_MAX_KHZ * 1000 - 1) / (2 * `ID_CLK_MAX_KHZ * 1000))
// card clock cycles allowed between command end bit and response start bit
`define RESP_WAIT_MAX     64
`define OPCOND_TRIES      1000

`define CMD_GO_IDLE       6'h00
`define CMD_OPCOND        6'h01
`define CMD_ALL_CID       6'h02
`define CMD_REL_ADDR      6'h03
`define CMD_APP           6'h37
`define CMD_SD_OPCOND     6'h29

`define FRAME_MSB         6'h2f
`define SHORT_BITS        8'h30
`define LONG_BITS         8'h88
`define CID_FIRST_BITS    8'h18
`define CID_WORDS         8
`define CID_WIDTH         16

`define OCR_ARG           32'h00ff_8000
`define MMC_RCA_DEFAULT   16'h0001
`define OCR_READY_BIT     39
`define RCA_MSB           39
`define RCA_LSB           24

`endif

// *** rtl/card_ident_pkg.sv ***
/*
 * Types of the card identification host: sequencer and link states,
 * command request and status carriers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package card_ident_pkg;

	typedef enum {
		SEQ_WAIT_CARD,
		SEQ_GO_IDLE,
		SEQ_APP_CMD,
		SEQ_SD_OPCOND,
		SEQ_MMC_OPCOND,
		SEQ_ALL_CID,
		SEQ_REL_ADDR,
		SEQ_DONE,
		SEQ_FAIL
	} seq_state_t;

	typedef enum {
		LINK_IDLE,
		LINK_SEND,
		LINK_WAIT,
		LINK_RECV,
		LINK_END
	} link_state_t;

	typedef struct packed {
		logic [5:0]  index;
		logic [31:0] arg;
		logic        long_resp;
		logic        no_resp;
	} cmd_req_t;

	typedef struct packed {
		logic busy;
		logic done;
		logic fail;
		logic sd_card;
		logic push_pull;
	} ident_status_t;

endpackage

// *** rtl/cid_store.sv ***
/*
 * Small word store for the card identification number, one write port,
 * one read port with registered read data.
 * Assumes write and read come from the same clock domain.
 */
`timescale 1ns/1ps
module cid_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic                     clock,
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [WIDTH-1:0]         wdata,
	input  wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic      [WIDTH-1:0]         rdata
);
	logic [WIDTH-1:0] mem_reg [DEPTH];

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
			$error("cid_store: depth must be a power of two and width positive");
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (we) begin
			mem_reg[waddr] <= wdata;
		end
	end

	always_ff @(posedge clock) begin
		rdata <= mem_reg[raddr];
	end
endmodule

// *** rtl/card_ident_host.sv ***
/*
 * Card bus pin driver and identification sequencer: card detect on data
 * line 3, reset, supply validation, CID collection and address assignment.
 * Assumes pins are already routed to this block and a 20 MHz clock.
 */
// What this block does
// - command line is open-drain during identification, push-pull afterwards
// - card clock is always an output driven by this block
// - one driver per data line; host leaves data lines released here
// - identification mode after reset and on every new card search
// - order is detect, reset, validate supply, identify, assign address
// - card insertion is seen as data line 3 going high
// - detect sampling runs on the system clock in every state
// - cards are idle after power-up and after go-idle command
// - card clock stays at or below 400 kHz during identification
// - app-command prefix always goes right before SD operating-condition command
// - timeout on app-command prefix leads to multimedia operating-condition probe
// - timeout on multimedia operating-condition command reports identification failure
// - after operating conditions, read card identification number
// - last step asks an SD card to publish its relative address, or assigns one to a multimedia card, for transfer mode
// - after address published, card is standby and command line push-pull
// - relative card address is sixteen bits wide
`include "card_ident_cfg.svh"
`timescale 1ns/1ps
module card_ident_host import card_ident_pkg::*; #(
	parameter int          RESP_WAIT = `RESP_WAIT_MAX,
	parameter int          OP_TRIES  = `OPCOND_TRIES,
	parameter logic [15:0] MMC_RCA   = `MMC_RCA_DEFAULT
) (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       search_start,
	input  wire logic       card_cmd_line_in,
	output logic            card_cmd_line_out,
	output logic            card_cmd_line_oe,
	output logic            card_clock_out,
	input  wire logic [3:0] card_data_lines_in,
	output logic [3:0]      card_data_lines_out,
	output logic [3:0]      card_data_lines_oe,
	output logic            card_present,
	output ident_status_t   ident_status,
	output logic [15:0]     card_rca,
	input  wire logic [2:0] cid_index,
	output logic [15:0]     cid_word
);
	localparam int ID_HALF = `ID_CLK_HALF;
	localparam int DIVW    = $clog2(ID_HALF + 1);

	generate
		if (RESP_WAIT < 1 || RESP_WAIT > 255 || OP_TRIES < 1 || OP_TRIES > 65535) begin : g_bad
			$error("card_ident_host: response wait or retry count out of range");
		end
	endgenerate

	seq_state_t    seq_reg;
	link_state_t   link_reg;
	logic          cmd_s1_reg;
	logic          cmd_s2_reg;
	logic          dat3_s1_reg;
	logic          dat3_s2_reg;
	logic          present_reg;
	logic [DIVW-1:0] div_reg;
	logic          clk_reg;
	logic [47:0]   tx_reg;
	logic [5:0]    tx_cnt_reg;
	logic          long_reg;
	logic          nores_reg;
	logic          timeout_reg;
	logic [7:0]    wait_reg;
	logic [7:0]    rx_cnt_reg;
	logic [135:0]  rx_reg;
	logic [15:0]   tries_reg;
	logic [15:0]   rca_reg;
	logic          sd_reg;
	logic          pp_reg;
	logic          cmd_out_reg;
	logic          cmd_oe_reg;
	ident_status_t status_reg;
	logic          busy;
	logic          tick;
	logic          rise_en;
	logic          fall_en;
	logic          detect_rise;
	logic          link_end;
	logic          search;
	logic [7:0]    rx_cnt_next;
	logic          cid_we;
	logic [2:0]    cid_waddr;
	cmd_req_t      req;
	logic [39:0]   head;

	function automatic logic [6:0] crc7(input logic [39:0] d);
		logic [6:0] c;
		logic       fb;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			fb = d[i] ^ c[6];
			c  = {c[5:0], 1'b0};
			if (fb) begin
				c = c ^ 7'h09;
			end
		end
		return c;
	endfunction

	function automatic cmd_req_t cmd_of(input seq_state_t s, input logic sd, input logic [15:0] rca);
		cmd_req_t r;
		r = '0;
		case (s)
			SEQ_GO_IDLE: r.no_resp = 1'b1;
			SEQ_APP_CMD: r.index = `CMD_APP;
			SEQ_SD_OPCOND: begin
				r.index = `CMD_SD_OPCOND;
				r.arg   = `OCR_ARG;
			end
			SEQ_MMC_OPCOND: begin
				r.index = `CMD_OPCOND;
				r.arg   = `OCR_ARG;
			end
			SEQ_ALL_CID: begin
				r.index     = `CMD_ALL_CID;
				r.long_resp = 1'b1;
			end
			SEQ_REL_ADDR: begin
				r.index = `CMD_REL_ADDR;
				r.arg   = sd ? 32'h0000_0000 : {rca, 16'h0000};
			end
			default: r.index = `CMD_GO_IDLE;
		endcase
		return r;
	endfunction

	assign busy        = !(seq_reg inside {SEQ_WAIT_CARD, SEQ_DONE, SEQ_FAIL});
	assign tick        = div_reg == DIVW'(ID_HALF - 1);
	assign rise_en     = tick && !clk_reg;
	assign fall_en     = tick && clk_reg;
	assign detect_rise = dat3_s2_reg && !present_reg;
	assign link_end    = link_reg == LINK_END;
	assign search      = search_start || detect_rise;
	assign req         = cmd_of(seq_reg, sd_reg, MMC_RCA);
	assign head        = {2'b01, req.index, req.arg};
	assign rx_cnt_next = rx_cnt_reg + 8'h01;
	assign cid_we      = link_reg == LINK_RECV && rise_en && long_reg && rx_cnt_next >= `CID_FIRST_BITS
	                     && rx_cnt_next[3:0] == 4'h8;
	assign cid_waddr   = 3'((rx_cnt_next - `CID_FIRST_BITS) >> 4);

	// pin synchronisers
	always_ff @(posedge clock) begin
		if (!nrst) begin
			cmd_s1_reg  <= 1'b1;
			cmd_s2_reg  <= 1'b1;
			dat3_s1_reg <= 1'b0;
			dat3_s2_reg <= 1'b0;
			present_reg <= 1'b0;
		end else begin
			cmd_s1_reg  <= card_cmd_line_in;
			cmd_s2_reg  <= cmd_s1_reg;
			dat3_s1_reg <= card_data_lines_in[3];
			dat3_s2_reg <= dat3_s1_reg;
			present_reg <= dat3_s2_reg;
		end
	end

	// card clock from divider; once idle it finishes a high phase and rests low, no runt pulse
	always_ff @(posedge clock) begin
		if (!nrst || (!busy && !clk_reg)) begin
			div_reg <= '0;
			clk_reg <= 1'b0;
		end else if (tick) begin
			div_reg <= '0;
			clk_reg <= !clk_reg;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	// command frame out, response in
	always_ff @(posedge clock) begin
		if (!nrst) begin
			link_reg    <= LINK_IDLE;
			tx_reg      <= '0;
			tx_cnt_reg  <= '0;
			long_reg    <= 1'b0;
			nores_reg   <= 1'b0;
			timeout_reg <= 1'b0;
			wait_reg    <= '0;
			rx_cnt_reg  <= '0;
			rx_reg      <= '0;
		end else begin
			case (link_reg)
				LINK_IDLE: if (busy && fall_en) begin
					tx_reg      <= {head, crc7(head), 1'b1};
					tx_cnt_reg  <= `FRAME_MSB;
					long_reg    <= req.long_resp;
					nores_reg   <= req.no_resp;
					timeout_reg <= 1'b0;
					link_reg    <= LINK_SEND;
				end
				LINK_SEND: if (fall_en) begin
					if (tx_cnt_reg == 6'h00) begin
						link_reg <= nores_reg ? LINK_END : LINK_WAIT;
						wait_reg <= '0;
					end else begin
						tx_reg     <= {tx_reg[46:0], 1'b0};
						tx_cnt_reg <= tx_cnt_reg - 6'h01;
					end
				end
				LINK_WAIT: if (rise_en) begin
					if (!cmd_s2_reg) begin
						link_reg   <= LINK_RECV;
						rx_cnt_reg <= 8'h01;
						rx_reg     <= {rx_reg[134:0], 1'b0};
					end else if (wait_reg == 8'(RESP_WAIT)) begin
						timeout_reg <= 1'b1;
						link_reg    <= LINK_END;
					end else begin
						wait_reg <= wait_reg + 8'h01;
					end
				end
				LINK_RECV: if (rise_en) begin
					rx_reg     <= {rx_reg[134:0], cmd_s2_reg};
					rx_cnt_reg <= rx_cnt_next;
					if (rx_cnt_next == (long_reg ? `LONG_BITS : `SHORT_BITS)) begin
						link_reg <= LINK_END;
					end
				end
				default: link_reg <= LINK_IDLE;
			endcase
		end
	end

	// command pin drive
	always_ff @(posedge clock) begin
		if (!nrst) begin
			cmd_out_reg <= 1'b0;
			cmd_oe_reg  <= 1'b0;
		end else if (link_reg == LINK_SEND && pp_reg) begin
			cmd_out_reg <= tx_reg[47];
			cmd_oe_reg  <= 1'b1;
		end else begin
			cmd_out_reg <= 1'b0;
			cmd_oe_reg  <= link_reg == LINK_SEND && !tx_reg[47];
		end
	end

	// identification sequencer
	always_ff @(posedge clock) begin
		if (!nrst) begin
			seq_reg   <= SEQ_WAIT_CARD;
			tries_reg <= '0;
			sd_reg    <= 1'b0;
			pp_reg    <= 1'b0;
			rca_reg   <= '0;
		end else begin
			case (seq_reg)
				SEQ_WAIT_CARD, SEQ_DONE, SEQ_FAIL: if (search) begin
					seq_reg   <= SEQ_GO_IDLE;
					pp_reg    <= 1'b0;
					sd_reg    <= 1'b0;
					tries_reg <= '0;
				end
				SEQ_GO_IDLE: if (link_end) begin
					seq_reg <= SEQ_APP_CMD;
				end
				SEQ_APP_CMD: if (link_end) begin
					seq_reg <= timeout_reg ? SEQ_MMC_OPCOND : SEQ_SD_OPCOND;
				end
				SEQ_SD_OPCOND, SEQ_MMC_OPCOND: if (link_end) begin
					if (timeout_reg) begin
						seq_reg <= SEQ_FAIL;
					end else if (rx_reg[`OCR_READY_BIT]) begin
						sd_reg  <= seq_reg == SEQ_SD_OPCOND;
						seq_reg <= SEQ_ALL_CID;
					end else if (tries_reg == 16'(OP_TRIES - 1)) begin
						seq_reg <= SEQ_FAIL;
					end else begin
						tries_reg <= tries_reg + 16'h0001;
						if (seq_reg == SEQ_SD_OPCOND) begin
							seq_reg <= SEQ_APP_CMD;
						end
					end
				end
				SEQ_ALL_CID: if (link_end) begin
					seq_reg <= timeout_reg ? SEQ_FAIL : SEQ_REL_ADDR;
				end
				default: if (link_end) begin
					if (timeout_reg) begin
						seq_reg <= SEQ_FAIL;
					end else begin
						rca_reg <= sd_reg ? rx_reg[`RCA_MSB:`RCA_LSB] : MMC_RCA;
						pp_reg  <= 1'b1;
						seq_reg <= SEQ_DONE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			status_reg <= '0;
		end else begin
			status_reg <= '{busy: busy, done: seq_reg == SEQ_DONE, fail: seq_reg == SEQ_FAIL,
			                sd_card: sd_reg, push_pull: pp_reg};
		end
	end

	cid_store #(
		.WIDTH (`CID_WIDTH),
		.DEPTH (`CID_WORDS)
	) u_cid (
		.clock (clock),
		.we    (cid_we),
		.waddr (cid_waddr),
		.wdata ({rx_reg[14:0], cmd_s2_reg}),
		.raddr (cid_index),
		.rdata (cid_word)
	);

	assign card_cmd_line_out   = cmd_out_reg;
	assign card_cmd_line_oe    = cmd_oe_reg;
	assign card_clock_out      = clk_reg;
	assign card_data_lines_out = 4'h0;
	assign card_data_lines_oe  = 4'h0;
	assign card_present        = present_reg;
	assign ident_status        = status_reg;
	assign card_rca            = rca_reg;

	// assertion helper: cycles since last card clock edge
	logic [7:0] phase_reg;
	always_ff @(posedge clock) begin
		if (!nrst || (!busy && !clk_reg) || tick) begin
			phase_reg <= '0;
		end else begin
			phase_reg <= phase_reg + 8'h01;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	open_drain_a: assert property (!pp_reg && card_cmd_line_oe |-> !card_cmd_line_out)
		else $error("command line driven high in open-drain mode");
	clk_half_a: assert property ($changed(card_clock_out) |-> $past(phase_reg) == 8'(ID_HALF - 1))
		else $error("card clock half period too short");
	data_free_a: assert property (card_data_lines_oe == 4'h0)
		else $error("host drives a data line");
	search_ident_a: assert property (!busy && search |=> seq_reg == SEQ_GO_IDLE && !pp_reg ##1 !ident_status.push_pull)
		else $error("search did not restart identification");
	detect_go_a: assert property (seq_reg == SEQ_WAIT_CARD && dat3_s2_reg && !present_reg |=> seq_reg == SEQ_GO_IDLE)
		else $error("card insertion not acted on");
	app_prefix_a: assert property ($changed(seq_reg) && seq_reg == SEQ_SD_OPCOND |-> $past(seq_reg) == SEQ_APP_CMD)
		else $error("operating-condition command without prefix");
	mmc_probe_a: assert property (seq_reg == SEQ_APP_CMD && link_end && timeout_reg |=> seq_reg == SEQ_MMC_OPCOND)
		else $error("prefix timeout did not lead to multimedia probe");
	ident_fail_a: assert property (seq_reg == SEQ_MMC_OPCOND && link_end && timeout_reg |=> ##1 ident_status.fail)
		else $error("multimedia timeout not reported");
	cid_order_a: assert property ($changed(seq_reg) && seq_reg == SEQ_REL_ADDR |-> $past(seq_reg) == SEQ_ALL_CID)
		else $error("address step out of order");
	push_pull_a: assert property (seq_reg == SEQ_REL_ADDR && link_end && !timeout_reg |=> pp_reg ##1 ident_status.push_pull)
		else $error("no switch to push-pull after address");
	resp_limit_a: assert property (link_reg == LINK_WAIT && rise_en && cmd_s2_reg && wait_reg == 8'(RESP_WAIT)
		|=> link_end && timeout_reg)
		else $error("response timeout not flagged at limit");
endmodule

// *** dv/card_model.sv ***
/*
 * Behavioural card on the command wire: answers as an SD card,
 * a multimedia card, or not at all.
 * Assumes the bench resolves the pulled-up command wire.
 */
`timescale 1ns/1ps
module card_model (
	input  wire logic         card_clk,
	input  wire logic         cmd_wire,
	input  wire logic [1:0]   mode,
	input  wire logic [127:0] cid,
	input  wire logic [15:0]  rca,
	input  wire logic [2:0]   lag,
	output logic              cmd_out,
	output logic              cmd_oe,
	output logic              got,
	output logic [5:0]        got_index,
	output logic [31:0]       got_arg
);
	// mode: 0 absent, 1 sd, 2 multimedia
	logic [47:0]  frame;
	logic [135:0] resp;
	logic         ready;
	int           len;
	int           k;
	initial begin
		cmd_oe = 1'b0;
		cmd_out = 1'b1;
		got = 1'b0;
		ready = 1'b0;
		forever begin
			@(posedge card_clk);
			// card only listens on the clock, never drives data lines
			if (cmd_wire === 1'b0) begin
				frame = 48'h0;
				for (k = 0; k < 47; k++) begin
					@(posedge card_clk);
					frame = {frame[46:0], cmd_wire};
				end
				got_index = frame[45:40];
				got_arg = frame[39:8];
				got = 1'b1;
				#1 got = 1'b0;
				len = 48;
				resp = {2'b00, got_index, 32'h0000_0120, 8'hff, 88'h0};
				case (got_index)
					6'h00: begin
						ready = 1'b0;
						len = 0;
					end
					6'h37: if (mode != 2'd1) len = 0;
					6'h29: begin
						resp = {8'h3f, ready, 31'h00ff_8000, 8'hff, 88'h0};
						ready = 1'b1;
						if (mode != 2'd1) len = 0;
					end
					6'h01: begin
						resp = {8'h3f, 1'b1, 31'h00ff_8000, 8'hff, 88'h0};
						if (mode != 2'd2) len = 0;
					end
					6'h02: begin
						resp = {8'h3f, cid[127:1], 1'b1};
						len = 136;
					end
					6'h03: resp = {8'h03, (mode == 2'd1) ? rca : 16'h0000, 16'h0000, 8'hff, 88'h0};
					default: len = 0;
				endcase
				if (mode == 2'd0) len = 0;
				if (len > 0) begin
					repeat (lag) @(negedge card_clk);
					for (k = 0; k < len; k++) begin
						@(negedge card_clk);
						cmd_oe = 1'b1;
						cmd_out = resp[135 - k];
					end
					@(negedge card_clk);
					cmd_oe = 1'b0;
					cmd_out = 1'b1;
				end
			end
		end
	end
endmodule

// *** dv/card_ident_host_bench.sv ***
/*
 * Bench of the card identification host: SD, multimedia and empty-slot
 * searches against the behavioural card, with pin monitors.
 * Assumes the design files and the card model are compiled first.
 */
`timescale 1ns/1ps
module card_ident_host_bench import card_ident_pkg::*;;
	logic          clock = 1'b0;
	logic          nrst = 1'b0;
	logic          search_start = 1'b0;
	logic          dat3 = 1'b0;
	logic [2:0]    cid_index = 3'h0;
	logic [1:0]    mode = 2'd0;
	logic [127:0]  cid = 128'h0;
	logic [15:0]   rca = 16'h0000;
	logic [2:0]    lag = 3'd2;
	logic          host_out, host_oe, card_clock_out, card_present, m_out, m_oe, got;
	logic [3:0]    dat_oe, dat_out;
	logic [5:0]    got_index;
	logic [31:0]   got_arg;
	logic [15:0]   card_rca, cid_word;
	ident_status_t ident_status;
	logic [5:0]    seen[$];
	logic [15:0]   od_bad = 16'h0000;
	logic [15:0]   dat_bad = 16'h0000;
	logic          clk_prev = 1'b0;
	int            run_len = 1000;
	int            min_half = 1000;
	int            failures = 0;
	int            n_checks = 0;
	// pulled-up wire, either party may pull it low
	wire           cmd_wire = (host_oe ? host_out : 1'b1) & (m_oe ? m_out : 1'b1);

	card_ident_host #(.RESP_WAIT(16), .OP_TRIES(3)) uut ( // pins wired straight to the block
		.clock(clock), .nrst(nrst), .search_start(search_start),
		.card_cmd_line_in(cmd_wire), .card_cmd_line_out(host_out), .card_cmd_line_oe(host_oe),
		.card_clock_out(card_clock_out), .card_data_lines_in({dat3, 3'b111}),
		.card_data_lines_out(dat_out), .card_data_lines_oe(dat_oe), .card_present(card_present),
		.ident_status(ident_status), .card_rca(card_rca), .cid_index(cid_index), .cid_word(cid_word));

	card_model card (
		.card_clk(card_clock_out), .cmd_wire(cmd_wire), .mode(mode), .cid(cid), .rca(rca),
		.lag(lag), .cmd_out(m_out), .cmd_oe(m_oe), .got(got), .got_index(got_index), .got_arg(got_arg));

	always @(posedge got) seen.push_back(got_index);

	always @(negedge clock) begin
		if (host_oe === 1'b1 && ident_status.push_pull !== 1'b1 && host_out !== 1'b0) od_bad++;
		if (dat_oe !== 4'h0 || dat_out !== 4'h0) dat_bad++;
		if (card_clock_out !== clk_prev) begin
			// a cut made by reset is not a half period
			if (nrst && run_len < min_half) min_half = run_len;
			run_len = 1;
		end else run_len++;
		clk_prev = card_clock_out;
	end

	task automatic check_flag(input string what, input logic exp, input logic seen_v);
		n_checks++;
		if (seen_v !== exp) begin
			failures++;
			$display("unexpected %s: expected %b, seen %b", what, exp, seen_v);
		end
	endtask

	task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] seen_v);
		n_checks++;
		if (seen_v !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen_v);
		end
	endtask

	function automatic logic [47:0] order_of(input logic [1:0] m);
		case (m)
			2'd1: order_of = {6'h00, 6'h37, 6'h29, 6'h37, 6'h29, 6'h02, 6'h03, 6'h3f};
			2'd2: order_of = {6'h00, 6'h37, 6'h01, 6'h02, 6'h03, 6'h3f, 6'h3f, 6'h3f};
			default: order_of = {6'h00, 6'h37, 6'h01, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f};
		endcase
	endfunction

	task automatic do_reset;
		nrst = 1'b0;
		repeat (20) @(negedge clock);
		check_word("status", 16'h0000, {11'h000, ident_status});
		check_word("rca_reset", 16'h0000, card_rca);
		check_flag("card_clock_idle", 1'b0, card_clock_out);
		nrst = 1'b1;
	endtask

	task automatic run_card(input logic [1:0] m, input logic by_detect);
		logic [47:0] exp_order;
		logic [5:0]  got_cmd;
		int          i;
		mode = m;
		cid = {$urandom(), $urandom(), $urandom(), $urandom()} | 128'h1;
		rca = 16'($urandom());
		lag = 3'd2 + 3'($urandom_range(3));
		exp_order = order_of(m);
		seen.delete();
		dat3 = by_detect; // detect held steady during card access
		search_start = ~by_detect;
		@(negedge clock);
		search_start = 1'b0;
		repeat (4) @(negedge clock);
		check_flag("card_present", by_detect, card_present);
		check_flag("busy", 1'b1, ident_status.busy);
		check_flag("push_pull_ident", 1'b0, ident_status.push_pull);
		repeat (3000) @(negedge clock);
		// a search while busy must be ignored
		search_start = 1'b1;
		@(negedge clock);
		search_start = 1'b0;
		for (i = 0; i < 80000; i++) begin
			if (ident_status.done === 1'b1 || ident_status.fail === 1'b1) break;
			@(negedge clock);
		end
		check_flag("done", m != 2'd0, ident_status.done);
		check_flag("fail", m == 2'd0, ident_status.fail);
		check_flag("sd_card", m == 2'd1, ident_status.sd_card);
		check_flag("push_pull", m != 2'd0, ident_status.push_pull);
		for (i = 0; i < 8; i++) begin
			got_cmd = (i < seen.size()) ? seen[i] : 6'h3f;
			check_word("command", {10'h000, exp_order[47 - 6 * i -: 6]}, {10'h000, got_cmd});
		end
		if (m != 2'd0) begin
			check_word("card_rca", (m == 2'd1) ? rca : 16'h0001, card_rca);
			for (i = 0; i < 8; i++) begin
				cid_index = 3'(i);
				@(negedge clock);
				check_word("cid_word", cid[127 - 16 * i -: 16], cid_word);
			end
		end
		if (m == 2'd2) check_word("rca_arg", 16'h0001, got_arg[31:16]);
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial forever #25 clock = ~clock;

	initial begin
		#4_750_000;
		failures++;
		tally_and_finish;
	end

	initial begin
		void'($urandom(32'h9b40));
		do_reset;
		run_card(2'd1, 1'b1);
		run_card(2'd2, 1'b0);
		run_card(2'd0, 1'b0);
		do_reset;
		check_word("open_drain_high", 16'h0000, od_bad);
		check_word("data_driven", 16'h0000, dat_bad);
		check_flag("card_clock_slow", 1'b1, min_half >= 25);
		tally_and_finish;
	end
endmodule
